/* File: core/serial_fram_spi_slave_front.v */
// Operation
// - 2048 byte locations, each chosen by an 11-bit address.
// - Two address bytes received; top five bits ignored.
// - Byte writes complete at once; no busy state exists.
// - Slave only, modes 0 and 3, clock up to 5 MHz.
// - SI sampled on rising SCK; first rising edge after select is opcode MSB.
// - SO changes only on falling SCK while selected.
// - First byte after select is the opcode; address and data follow.
// - Deselected: SI ignored, SO released.
// - All bytes travel most significant bit first.
// - Device never starts bus activity itself.
// - Unknown opcode: ignore SI until next select, keep SO released.
// - An 8-bit status register configures the device.
// - Mode 0 if SCK low at select, mode 3 if high.
// - Six opcodes recognised; all others invalid.
// - SO driven only while read data is returned.
`timescale 1ns/1ps
`include "spi_fram_regs.vh"
module serial_fram_spi_slave_front
(
    input  wire core_clk,    // 40 MHz system clock
    input  wire reset,       // Async reset, active high
    input  wire spiClk,      // Serial clock from master
    input  wire chipSelN,    // Chip select, active low
    input  wire serialIn,    // Serial data in
    input  wire writeProtN,  // Write protect pin, active low
    output reg  serialOut,   // Serial data out
    output reg  serialOutEn, // Low while serialOut is driven
    output reg  spiMode3     // Mode captured at last selection
);
    localparam ST_IDLE   = 3'd0;
    localparam ST_CMD    = 3'd1;
    localparam ST_ADDRHI = 3'd2;
    localparam ST_ADDRLO = 3'd3;
    localparam ST_DATA   = 3'd4;
    localparam ST_STAT   = 3'd5;
    localparam ST_IGNORE = 3'd6;

    wire sckS;
    wire csnS;
    wire siS;
    wire wpnS;

    sync_2ff uSck (.core_clk(core_clk), .reset(reset),
                   .asyncIn(spiClk), .syncOut(sckS));
    sync_2ff uCs (.core_clk(core_clk), .reset(reset),
                  .asyncIn(chipSelN), .syncOut(csnS));
    sync_2ff uSi (.core_clk(core_clk), .reset(reset),
                  .asyncIn(serialIn), .syncOut(siS));
    sync_2ff uWp (.core_clk(core_clk), .reset(reset),
                  .asyncIn(writeProtN), .syncOut(wpnS));

    reg  [7:0]  mem [0:`MEM_DEPTH-1];
    reg  [2:0]  state_q;
    reg  [7:0]  cmd_q;
    reg  [7:0]  shift_q;
    reg  [2:0]  bitCnt_q;
    reg  [`ADDR_BITS-1:0] addr_q;
    reg  [7:0]  status_q;
    reg  [7:0]  txByte_q;
    reg         reading_q;
    reg         wrOp_q;
    reg         sckPrev_q;
    reg         csnPrev_q;

    wire        sckRise = sckS & ~sckPrev_q;
    wire        sckFall = ~sckS & sckPrev_q;
    wire        csFall  = ~csnS & csnPrev_q;
    wire        csRise  = csnS & ~csnPrev_q;
    wire [7:0]  rxByte  = {shift_q[6:0], siS};
    wire        byteEnd = sckRise & (bitCnt_q == 3'd7);
    wire        wel     = status_q[`STATUS_WEL_BIT];
    wire [1:0]  bp      = {status_q[`STATUS_BP1_BIT],
                           status_q[`STATUS_BP0_BIT]};
    wire        statLock = status_q[`STATUS_WPEN_BIT] & ~wpnS;
    reg         blockProt;
    reg         validCmd;

    always @*
    begin
        case (bp)
            2'b01:   blockProt = (addr_q[10:9] == 2'b11);
            2'b10:   blockProt = addr_q[10];
            2'b11:   blockProt = 1'b1;
            default: blockProt = 1'b0;
        endcase
        case (rxByte)
            `CMD_SET_WRITE_LATCH, `CMD_CLEAR_WRITE_LATCH,
            `CMD_STATUS_READ, `CMD_STATUS_WRITE,
            `CMD_MEM_READ, `CMD_MEM_WRITE: validCmd = 1'b1;
            default: validCmd = 1'b0;
        endcase
    end

    always @(posedge core_clk)
    begin
        // Write lands as the last bit is taken, before any next byte
        if (state_q == ST_DATA && byteEnd && cmd_q == `CMD_MEM_WRITE
            && wel && !blockProt && !csnS)
            mem[addr_q] <= rxByte;
    end

    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            state_q     <= ST_IDLE;
            cmd_q       <= 8'h00;
            shift_q     <= 8'h00;
            bitCnt_q    <= 3'd0;
            addr_q      <= {`ADDR_BITS{1'b0}};
            status_q    <= `STATUS_RESET;
            txByte_q    <= 8'h00;
            reading_q   <= 1'b0;
            wrOp_q      <= 1'b0;
            sckPrev_q   <= 1'b0;
            csnPrev_q   <= 1'b1;
            serialOut   <= 1'b0;
            serialOutEn <= 1'b1;
            spiMode3    <= 1'b0;
        end
        else
        begin
            sckPrev_q <= sckS;
            csnPrev_q <= csnS;
            if (csnS)
            begin
                // Deselected: ignore SI, release SO
                state_q     <= ST_IDLE;
                reading_q   <= 1'b0;
                serialOutEn <= 1'b1;
                if (csRise && wrOp_q)
                    status_q[`STATUS_WEL_BIT] <= 1'b0;
                wrOp_q <= 1'b0;
            end
            else if (csFall)
            begin
                // Selection opens a new instruction
                spiMode3 <= sckS;
                state_q  <= ST_CMD;
                bitCnt_q <= 3'd0;
                shift_q  <= 8'h00;
            end
            else if (state_q != ST_IDLE && state_q != ST_IGNORE)
            begin
                if (sckRise)
                begin
                    // Sample SI on rising edge, MSB first
                    shift_q  <= rxByte;
                    bitCnt_q <= bitCnt_q + 3'd1;
                end
                if (sckFall && reading_q)
                begin
                    // Output moves on falling edge only
                    serialOut   <= txByte_q[7];
                    txByte_q    <= {txByte_q[6:0], 1'b0};
                    serialOutEn <= 1'b0;
                end
                if (byteEnd)
                begin
                    case (state_q)
                        ST_CMD:
                        begin
                            cmd_q <= rxByte;
                            if (!validCmd)
                                state_q <= ST_IGNORE;
                            else if (rxByte == `CMD_SET_WRITE_LATCH)
                            begin
                                status_q[`STATUS_WEL_BIT] <= 1'b1;
                                state_q <= ST_IGNORE;
                            end
                            else if (rxByte == `CMD_CLEAR_WRITE_LATCH)
                            begin
                                wrOp_q  <= 1'b1;
                                state_q <= ST_IGNORE;
                            end
                            else if (rxByte == `CMD_STATUS_READ)
                            begin
                                txByte_q  <= status_q;
                                reading_q <= 1'b1;
                                state_q   <= ST_STAT;
                            end
                            else if (rxByte == `CMD_STATUS_WRITE)
                                state_q <= ST_STAT;
                            else
                                state_q <= ST_ADDRHI;
                        end
                        ST_ADDRHI:
                        begin
                            // Top five address bits dropped
                            addr_q[10:8] <= rxByte[2:0];
                            state_q      <= ST_ADDRLO;
                        end
                        ST_ADDRLO:
                        begin
                            addr_q[7:0] <= rxByte;
                            state_q     <= ST_DATA;
                            if (cmd_q == `CMD_MEM_READ)
                            begin
                                txByte_q  <= mem[{addr_q[10:8], rxByte}];
                                reading_q <= 1'b1;
                            end
                            else
                                wrOp_q <= 1'b1;
                        end
                        ST_DATA:
                        begin
                            // Address wraps within 2048 bytes
                            addr_q <= addr_q + 11'd1;
                            if (cmd_q == `CMD_MEM_READ)
                                txByte_q <= mem[addr_q + 11'd1];
                        end
                        ST_STAT:
                        begin
                            if (cmd_q == `CMD_STATUS_WRITE)
                            begin
                                wrOp_q <= 1'b1;
                                if (wel && !statLock)
                                    status_q <= (rxByte
                                        & `STATUS_WRITE_MASK)
                                        | (status_q
                                        & ~`STATUS_WRITE_MASK);
                                state_q <= ST_IGNORE;
                            end
                            else
                                txByte_q <= status_q;
                        end
                        default: state_q <= ST_IGNORE;
                    endcase
                end
            end
        end
    end
endmodule

/* File: core/spi_fram_regs.vh */
`ifndef SPI_FRAM_REGS_VH
`define SPI_FRAM_REGS_VH
`define MEM_DEPTH         2048
`define ADDR_BITS         11
`define ADDR_IGNORED      5
`define CMD_SET_WRITE_LATCH   8'h06
`define CMD_CLEAR_WRITE_LATCH 8'h04
`define CMD_STATUS_READ       8'h05
`define CMD_STATUS_WRITE      8'h01
`define CMD_MEM_READ          8'h03
`define CMD_MEM_WRITE         8'h02
`define STATUS_RESET      8'h00
`define STATUS_WEL_BIT    1
`define STATUS_WRITE_MASK 8'h8C
`define STATUS_BP0_BIT    2
`define STATUS_BP1_BIT    3
`define STATUS_WPEN_BIT   7
`endif

/* File: core/sync_2ff.v */
`timescale 1ns/1ps
module sync_2ff
(
    input  wire core_clk, // System clock
    input  wire reset,    // Async reset, active high
    input  wire asyncIn,  // Signal from outside the domain
    output reg  syncOut   // Synchronised level
);
    reg stage1_q;

    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            stage1_q <= 1'b0;
            syncOut  <= 1'b0;
        end
        else
        begin
            stage1_q <= asyncIn;
            syncOut  <= stage1_q;
        end
    end
endmodule

/* File: sim/spi_master_model.sv */
`timescale 1ns/1ps
module spi_master_model
(
    input  wire core_clk,    // Bench clock
    input  wire serialOut,   // Data from the slave
    input  wire serialOutEn, // Low while the slave drives
    output reg  spiClk,      // Serial clock
    output reg  chipSelN,    // Chip select, active low
    output reg  serialIn     // Data to the slave
);
    reg  idleClk;
    reg  lastBit;
    // A released line shows the inverse of its last value
    wire misoLine = serialOutEn ? ~lastBit : serialOut;
    initial
    begin
        spiClk = 1'b0;
        chipSelN = 1'b1;
        serialIn = 1'b0;
        idleClk = 1'b0;
        lastBit = 1'b0;
    end
    task halfWait;
        repeat (4) @(negedge core_clk);
    endtask
    task sel(input logic m3);
    begin
        idleClk = m3;
        spiClk = m3;
        halfWait;
        chipSelN = 1'b0;
        halfWait;
    end
    endtask
    task xfer(input logic [7:0] tx, output logic [7:0] rx);
        integer i;
    begin
        for (i = 7; i >= 0; i = i - 1)
        begin
            spiClk = 1'b0;
            serialIn = tx[i];
            halfWait;
            spiClk = 1'b1;
            halfWait;
            rx[i] = misoLine;
            lastBit = rx[i];
        end
    end
    endtask
    task rel;
    begin
        spiClk = idleClk;
        halfWait;
        chipSelN = 1'b1;
        serialIn = ~serialIn;
        halfWait;
        halfWait;
    end
    endtask
endmodule

/* File: sim/serial_fram_spi_slave_front_sva.sv */
`timescale 1ns/1ps
module serial_fram_spi_slave_front_sva
(
    input wire core_clk,    // System clock
    input wire reset,       // Async reset, active high
    input wire spiClk,      // Serial clock
    input wire chipSelN,    // Chip select, active low
    input wire serialIn,    // Serial data in
    input wire writeProtN,  // Write protect, active low
    input wire serialOut,   // Serial data out
    input wire serialOutEn, // Low while driving
    input wire spiMode3     // Captured mode
);
    reg [3:0] fallAge_q;
    reg [3:0] csFall_q;
    // Saturating ages of the last clock fall and select fall
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            fallAge_q <= 4'hF;
            csFall_q <= 4'hF;
        end
        else
        begin
            fallAge_q <= $fell(spiClk) ? 4'h0
                       : fallAge_q + {3'h0, fallAge_q != 4'hF};
            csFall_q <= $fell(chipSelN) ? 4'h0
                      : csFall_q + {3'h0, csFall_q != 4'hF};
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    rst_vals_a: assert property (
        $fell(reset) |-> serialOutEn && !spiMode3)
        else $error("outputs wrong after reset");
    idle_release_a: assert property (
        chipSelN [*6] |-> serialOutEn)
        else $error("output driven while deselected");
    drive_selected_a: assert property (
        !serialOutEn |-> !$past(chipSelN, 5))
        else $error("output driven without selection");
    drive_on_fall_a: assert property (
        $fell(serialOutEn) |-> fallAge_q <= 4'h6)
        else $error("drive started off a clock fall");
    out_on_fall_a: assert property (
        !serialOutEn && $changed(serialOut) |-> fallAge_q <= 4'h6)
        else $error("data changed off a clock fall");
    mode_three_a: assert property (
        $fell(chipSelN) && spiClk |-> ##[2:6] spiMode3)
        else $error("mode 3 not captured");
    mode_zero_a: assert property (
        $fell(chipSelN) && !spiClk |-> ##[2:6] !spiMode3)
        else $error("mode 0 not captured");
    mode_hold_a: assert property (
        $changed(spiMode3) |-> csFall_q <= 4'h6)
        else $error("mode changed outside selection");
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    reg         core_clk;
    reg         reset;
    reg         writeProtN;
    wire        spiClk;
    wire        chipSelN;
    wire        serialIn;
    wire        serialOut;
    wire        serialOutEn;
    wire        spiMode3;
    integer     bad_count;
    integer     tests_run;
    integer     n;
    reg  [31:0] seed;
    reg  [15:0] addr;
    reg  [7:0]  data;
    reg  [7:0]  rx;
    reg  [7:0]  badOp;
    reg         mode;
    integer     driveCnt;
    integer     driveMark;
    serial_fram_spi_slave_front dut (.core_clk(core_clk), .reset(reset),
        .spiClk(spiClk), .chipSelN(chipSelN), .serialIn(serialIn),
        .writeProtN(writeProtN), .serialOut(serialOut),
        .serialOutEn(serialOutEn), .spiMode3(spiMode3));
    spi_master_model master (.core_clk(core_clk), .serialOut(serialOut),
        .serialOutEn(serialOutEn), .spiClk(spiClk), .chipSelN(chipSelN),
        .serialIn(serialIn));
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
    begin
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    end
    endfunction
    task check(input [7:0] got, input [7:0] exp);
    begin
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    end
    endtask
    // One selection: opcode, then address and data as the length asks
    task access(input m, input [7:0] op, input [15:0] a, input integer len,
                input [7:0] d);
    begin
        master.sel(m);
        master.xfer(op, rx);
        if (len > 2)
        begin
            master.xfer(a[15:8], rx);
            master.xfer(a[7:0], rx);
        end
        if (len > 1)
            master.xfer(d, rx);
        master.rel;
    end
    endtask
    task report_and_stop;
    begin
        if (bad_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    // Counts cycles in which the slave drives its output
    always @(posedge core_clk or posedge reset)
        if (reset)
            driveCnt <= 0;
        else if (!serialOutEn)
            driveCnt <= driveCnt + 1;
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial
    begin
        #2000000;
        bad_count = bad_count + 1;
        report_and_stop;
    end
    initial
    begin
        reset = 1'b1;
        writeProtN = 1'b1;
        bad_count = 0;
        tests_run = 0;
        seed = 32'h3AEB;
        repeat (4) @(negedge core_clk);
        reset = 1'b0;
        repeat (4) @(negedge core_clk);
        check({6'h00, spiMode3, serialOutEn}, 8'h01);
        access(1'b0, 8'h05, 16'h0000, 2, 8'h00);
        check(rx, 8'h00);
        access(1'b1, 8'h06, 16'h0000, 1, 8'h00);
        access(1'b1, 8'h05, 16'h0000, 2, 8'h00);
        check(rx, 8'h02);
        access(1'b0, 8'h04, 16'h0000, 1, 8'h00);
        access(1'b0, 8'h05, 16'h0000, 2, 8'h00);
        check(rx, 8'h00);
        for (n = 0; n < 8; n = n + 1)
        begin
            seed = xs(seed);
            addr = (n == 0) ? 16'hFFFF : (n == 1) ? 16'h0000 : seed[15:0];
            data = seed[23:16];
            mode = seed[24];
            access(mode, 8'h06, addr, 1, data);
            access(mode, 8'h02, addr, 4, data);
            seed = xs(seed);
            access(!mode, 8'h03, {seed[4:0], addr[10:0]}, 4, 8'h00);
            check(rx, data);
            check({7'h00, spiMode3}, {7'h00, !mode});
            badOp = seed[15:8];
            if (badOp >= 8'h01 && badOp <= 8'h06)
                badOp = badOp | 8'h80;
            access(mode, 8'h06, addr, 1, data);
            driveMark = driveCnt;
            access(mode, badOp, 16'h0203, 4, ~data);
            check({7'h00, driveCnt != driveMark}, 8'h00);
            access(mode, 8'h03, addr, 4, 8'h00);
            check(rx, data);
        end
        // Status write keeps only bits 7, 3 and 2; the latch drops after
        access(mode, 8'h06, addr, 1, data);
        access(mode, 8'h01, addr, 2, 8'hFF);
        access(mode, 8'h05, addr, 2, 8'h00);
        check(rx, 8'h8C);
        // Whole array protected now: the write must be refused
        access(mode, 8'h06, addr, 1, data);
        access(mode, 8'h02, addr, 4, ~data);
        access(mode, 8'h03, addr, 4, 8'h00);
        check(rx, data);
        // Protect pin low with protect enable set locks the status byte
        writeProtN = 1'b0;
        access(mode, 8'h06, addr, 1, data);
        access(mode, 8'h01, addr, 2, 8'h00);
        access(mode, 8'h05, addr, 2, 8'h00);
        check(rx, 8'h8C);
        writeProtN = 1'b1;
        access(mode, 8'h06, addr, 1, data);
        access(mode, 8'h01, addr, 2, 8'h00);
        access(mode, 8'h05, addr, 2, 8'h00);
        check(rx, 8'h00);
        report_and_stop;
    end
endmodule
bind serial_fram_spi_slave_front serial_fram_spi_slave_front_sva chk (
    .core_clk(core_clk), .reset(reset), .spiClk(spiClk),
    .chipSelN(chipSelN), .serialIn(serialIn), .writeProtN(writeProtN),
    .serialOut(serialOut), .serialOutEn(serialOutEn), .spiMode3(spiMode3));
